//--- inc/dsr_pkg.sv
// Shared constants for the separate-I/O double-data-rate SRAM bus port
package dsr_pkg;

  // ==========================================================================
  // Organisation
  localparam int DATA_W     = 36;  // Data bus width, 18 or 36
  localparam int ADDR_W     = 19;  // Address width, 20 for x18, 19 for x36
  localparam int LANE_W     = 9;   // Bits under one byte-lane select
  localparam int MEM_AW     = 4;   // Address bits actually stored in flops
  localparam int FIFO_DEPTH = 8;   // Read data words buffered

  // ==========================================================================
  // Synchronised pin vector layout
  localparam int SYNC_STAGES = 2;  // Flops before any logic reads a pin
  localparam int CTRL_BITS   = 7;  // Clocks, mode, load strobe, direction
  localparam int POS_K       = 0;
  localparam int POS_KN      = 1;
  localparam int POS_C       = 2;
  localparam int POS_CN      = 3;
  localparam int POS_SINGLE  = 4;
  localparam int POS_LOAD_N  = 5;
  localparam int POS_RW      = 6;

  // ==========================================================================
  // Reset values
  localparam logic       RST_OE   = 1'b0;  // Read bus released after reset
  localparam logic [1:0] RST_SYNC = 2'h0;

  // ==========================================================================
  // Port sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,  // Waiting for a load on a true input clock rise
    ST_WR_HI = 2'b01,  // Write word 0 stored, waiting for complementary rise
    ST_RD_W0 = 2'b10,  // Pushing read word 0 into the output buffer
    ST_RD_W1 = 2'b11   // Pushing read word 1 into the output buffer
  } dsr_state_type;

endpackage : dsr_pkg

//--- tb/dsr_host.sv
// Host controller model driving the link pins of the SRAM port
`timescale 1ns/1ps
module dsr_host (
  input  wire logic                                  sys_clk_in,  // Bench clock
  output logic                                       k_out,       // True in clock
  output logic                                       k_n_out,     // Comp in clock
  output logic                                       c_out,       // True out clock
  output logic                                       c_n_out,     // Comp out clock
  output logic                                       cycle_load_n_out, // Load, low
  output logic                                       read_write_out,   // Direction
  output logic [dsr_pkg::ADDR_W-1:0]                 addr_out,    // Address
  output logic [dsr_pkg::DATA_W-1:0]                 data_out,    // Write data
  output logic [dsr_pkg::DATA_W/9-1:0]               byte_lane_write_select_n_out, // Lanes
  input  wire logic [dsr_pkg::DATA_W-1:0]            q_in,        // Read data
  input  wire logic                                  q_oe_in      // Drive enable
);
  // Clocks stand still between frames, true leg low
  initial begin
    {k_out, k_n_out, c_out, c_n_out} = 4'h5;
    cycle_load_n_out = 1'b1;
    read_write_out = 1'b0;
    addr_out = '0;
    data_out = '0;
    byte_lane_write_select_n_out = '1;
  end
  task automatic wait_edges(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : wait_edges
  // One 64 ns link period; s0, s1 hold {enable, data} after each launch edge
  task automatic frame(input logic use_k, ld_n, rd, input logic [dsr_pkg::ADDR_W-1:0] a,
                       input logic [dsr_pkg::DATA_W-1:0] d0, d1,
                       input logic [dsr_pkg::DATA_W/9-1:0] m0, m1,
                       output logic [dsr_pkg::DATA_W:0] s0, s1);
    @(posedge sys_clk_in);
    #1;
    {k_out, k_n_out, c_out, c_n_out} = use_k ? 4'h9 : 4'h6;  // True edge
    cycle_load_n_out = ld_n;
    read_write_out = rd;
    addr_out = a;
    data_out = d0;
    byte_lane_write_select_n_out = m0;
    wait_edges(4);
    {k_out, k_n_out, c_out, c_n_out} = 4'h5;  // Complementary edge ends the burst
    cycle_load_n_out = 1'b1;
    data_out = d1;
    byte_lane_write_select_n_out = m1;
    wait_edges(2);
    s0 = {q_oe_in, q_in};
    wait_edges(1);
    s1 = {q_oe_in, q_in};
    // Released lines flip so a stale word never reads as valid; next rise is 64 ns on
    data_out = ~data_out;
    addr_out = ~addr_out;
    read_write_out = ~read_write_out;
    byte_lane_write_select_n_out = ~byte_lane_write_select_n_out;
  endtask : frame
endmodule : dsr_host

//--- tb/dsr_port_props.sv
// Port-level assertions for the SRAM bus port
`timescale 1ns/1ps
module dsr_port_props #(
  parameter int DATA_W = dsr_pkg::DATA_W,
  parameter int ADDR_W = dsr_pkg::ADDR_W,
  parameter int MEM_AW = dsr_pkg::MEM_AW
) (
  input wire logic                sys_clk_in,                   // Clock
  input wire logic                resetn_in,                    // Reset, low
  input wire logic                k_in,                         // True in clock
  input wire logic                k_n_in,                       // Comp in clock
  input wire logic                c_in,                         // True out clock
  input wire logic                c_n_in,                       // Comp out clock
  input wire logic                single_clock_mode_in,         // Mode
  input wire logic                cycle_load_n_in,              // Load, low
  input wire logic                read_write_in,                // Direction
  input wire logic [ADDR_W-1:0]   addr_in,                      // Address
  input wire logic [DATA_W-1:0]   data_in,                      // Write data
  input wire logic [DATA_W/9-1:0] byte_lane_write_select_n_in,  // Lanes, low
  input wire logic [DATA_W-1:0]   q_out,                        // Read data
  input wire logic                q_oe_out                      // Drive enable
);
  // ==========================================================================
  // Pin edges as the system clock sees them; the port adds its own sync delay
  logic [3:0] pins_reg, pins_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       rd_reg, rd_next;
  logic       k_rise, launch;
  always_comb begin
    pins_next = {k_in, k_n_in, c_in, c_n_in};
    k_rise    = k_in && !pins_reg[3];
    launch    = single_clock_mode_in ? (k_rise || (k_n_in && !pins_reg[2]))
                                     : ((c_in && !pins_reg[1]) || (c_n_in && !pins_reg[0]));
    cnt_next  = launch ? 3'h0 : cnt_reg + {2'h0, cnt_reg != 3'h7};  // Saturates at 7
    rd_next   = rd_reg || (k_rise && !cycle_load_n_in && read_write_in);
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pins_reg <= 4'h5;
      cnt_reg  <= 3'h7;
      rd_reg   <= 1'b0;
    end else begin
      pins_reg <= pins_next;
      cnt_reg  <= cnt_next;
      rd_reg   <= rd_next;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_quiet;
    cnt_reg == 3'h7 ##1 cnt_reg == 3'h7;
  endsequence
  sequence s_write_load;
    k_rise && !cycle_load_n_in && !read_write_in && !single_clock_mode_in && cnt_reg == 3'h7;
  endsequence
  property p_reset_quiet;
    disable iff (1'b0) !resetn_in && !$past(resetn_in) |-> !q_oe_out && q_out == '0;
  endproperty
  property p_release_quiet;
    $rose(resetn_in) |-> (!q_oe_out) [*3];
  endproperty
  property p_q_on_launch;
    $changed(q_out) |-> cnt_reg <= 3'h5;
  endproperty
  property p_oe_on_launch;
    $changed(q_oe_out) |-> cnt_reg <= 3'h5;
  endproperty
  property p_idle_quiet;
    s_quiet |-> $stable(q_out) && $stable(q_oe_out);
  endproperty
  property p_no_read_no_drive;
    !rd_reg |-> !q_oe_out && q_out == '0;
  endproperty
  property p_drive_after_read;
    $rose(q_oe_out) |-> $past(rd_reg, 2);
  endproperty
  property p_write_silent;
    s_write_load |=> $stable(q_out) [*5];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("read bus active during reset");
  a_release_quiet: assert property (p_release_quiet)
    else $error("read bus active after reset release");
  a_q_on_launch: assert property (p_q_on_launch)
    else $error("read data moved without a launch edge");
  a_oe_on_launch: assert property (p_oe_on_launch)
    else $error("drive enable moved without a launch edge");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("read bus moved while launch clocks stood");
  a_no_read_no_drive: assert property (p_no_read_no_drive)
    else $error("read bus driven before any read load");
  a_drive_after_read: assert property (p_drive_after_read)
    else $error("drive enable rose without a read");
  a_write_silent: assert property (p_write_silent)
    else $error("write access disturbed read data");
endmodule : dsr_port_props

bind dsr_port dsr_port_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .MEM_AW(MEM_AW)) u_props (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .k_in(k_in), .k_n_in(k_n_in),
  .c_in(c_in), .c_n_in(c_n_in), .single_clock_mode_in(single_clock_mode_in),
  .cycle_load_n_in(cycle_load_n_in), .read_write_in(read_write_in), .addr_in(addr_in),
  .data_in(data_in), .byte_lane_write_select_n_in(byte_lane_write_select_n_in),
  .q_out(q_out), .q_oe_out(q_oe_out));

//--- tb/test_ddr_sio_sram_bus_port.sv
// Self-checking bench for the SRAM bus port
`timescale 1ns/1ps
module test_ddr_sio_sram_bus_port;
  localparam int DW = dsr_pkg::DATA_W;
  localparam int AW = dsr_pkg::ADDR_W;
  localparam int NL = DW / 9;
  logic          sys_clk_in, resetn_in, single_clock_mode_in, k_in, k_n_in, c_in, c_n_in;
  logic          cycle_load_n_in, read_write_in, q_oe_out, exp_oe;
  logic [AW-1:0] addr_in;
  logic [DW-1:0] data_in, q_out, exp_word;
  logic [NL-1:0] byte_lane_write_select_n_in;
  logic [DW-1:0] mem0 [16];
  logic [DW-1:0] mem1 [16];
  logic [DW-1:0] exp_q [$];
  int            mismatches, samples_checked;
  dsr_port uut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .k_in(k_in), .k_n_in(k_n_in),
    .c_in(c_in), .c_n_in(c_n_in), .single_clock_mode_in(single_clock_mode_in),
    .cycle_load_n_in(cycle_load_n_in), .read_write_in(read_write_in), .addr_in(addr_in),
    .data_in(data_in), .byte_lane_write_select_n_in(byte_lane_write_select_n_in),
    .q_out(q_out), .q_oe_out(q_oe_out));
  dsr_host u_host (
    .sys_clk_in(sys_clk_in), .k_out(k_in), .k_n_out(k_n_in), .c_out(c_in), .c_n_out(c_n_in),
    .cycle_load_n_out(cycle_load_n_in), .read_write_out(read_write_in), .addr_out(addr_in),
    .data_out(data_in), .byte_lane_write_select_n_out(byte_lane_write_select_n_in),
    .q_in(q_out), .q_oe_in(q_oe_out));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Enable and data compared together; data only counts while driven
  task automatic check_s(input logic [DW:0] seen, input logic [DW:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR q_oe_out,q_out expected %h seen %h", want, seen);
    end
  endtask : check_s
  // An empty buffer at a launch edge releases the bus
  task automatic pop();
    exp_oe = exp_q.size() != 0;
    if (exp_oe) begin
      exp_word = exp_q.pop_front();
    end else begin
      exp_word = '0;
    end
  endtask : pop
  task automatic xfer(input logic use_k, ld_n, rd, input logic [AW-1:0] a,
                      input logic [DW-1:0] d0, d1, input logic [NL-1:0] m0, m1);
    logic [DW:0] s0, s1;
    logic        launch, load;
    logic [3:0]  i;
    launch = use_k == single_clock_mode_in;
    load = use_k && !ld_n;  // No true input edge, no access
    i = a[3:0];  // Upper bits alias in the short array
    u_host.frame(use_k, ld_n, rd, a, d0, d1, m0, m1, s0, s1);
    if (launch) pop();
    check_s({s0[DW], s0[DW-1:0] & {DW{exp_oe}}}, {exp_oe, exp_word});
    if (load && rd) begin
      exp_q.push_back(mem0[i]);
      exp_q.push_back(mem1[i]);
    end
    for (int g = 0; g < NL; g++) begin
      if (load && !rd && !m0[g]) mem0[i][9*g +: 9] = d0[9*g +: 9];
      if (load && !rd && !m1[g]) mem1[i][9*g +: 9] = d1[9*g +: 9];
    end
    if (launch) pop();
    check_s({s1[DW], s1[DW-1:0] & {DW{exp_oe}}}, {exp_oe, exp_word});
  endtask : xfer
  // Op 0 write, 1 read, 2 output clocks only, 3 true clocks with load high
  // Fixed puts address n and all lanes on
  task automatic rand_op(input int op, input logic fixed, input int n);
    logic [63:0] r0, r1;
    r0 = {$urandom(), $urandom()};
    r1 = {$urandom(), $urandom()};
    xfer(op != 2, op == 3 || (op == 2 && r1[36]), op == 1 || (op > 1 && r1[37]),
         fixed ? AW'(n) : r0[63-:AW],
         r0[DW-1:0], r1[DW-1:0], fixed ? {NL{1'b0}} : r1[63-:NL], fixed ? {NL{1'b0}} : r1[59-:NL]);
  endtask : rand_op
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    mismatches = 0;
    samples_checked = 0;
    exp_oe = 1'b0;
    exp_word = '0;
    resetn_in = 1'b0;
    single_clock_mode_in = 1'b0;
    void'($urandom(50));
    repeat (4) @(posedge sys_clk_in);
    #1 resetn_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    for (int n = 0; n < 16; n++) rand_op(0, 1'b1, n);
    // Fill the read buffer to its 8 words, then drain past empty
    for (int n = 0; n < 4; n++) rand_op(1, 1'b1, n);
    for (int n = 0; n < 5; n++) rand_op(2, 1'b1, n);
    for (int n = 0; n < 40; n++) rand_op(exp_q.size() <= 6 ? $urandom_range(3) : 2, 1'b0, 0);
    @(posedge sys_clk_in);
    #1 single_clock_mode_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    // True clock frames drain the buffer in single clock mode
    for (int n = 0; n < 40; n++) rand_op(exp_q.size() <= 6 ? $urandom_range(3) : 3, 1'b0, 0);
    // A second reset empties the buffer mid-run
    @(posedge sys_clk_in);
    #1 resetn_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1 resetn_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    exp_q.delete();
    exp_oe = 1'b0;
    exp_word = '0;
    // Any word left over from before the reset would show up here
    rand_op(0, 1'b1, 3);
    rand_op(1, 1'b1, 3);
    rand_op(3, 1'b0, 0);
    tally_and_finish();
  end
endmodule : test_ddr_sio_sram_bus_port

//--- verilog/dsr_port.sv
// Read data buffer and the SRAM bus port top module
`timescale 1ns/1ps

// How it works
// R1: Write data is taken at the true and then the complementary input clock rise.
// R2: Controller pulls the load strobe low to define a new transaction.
// R3: Every transaction moves exactly two data words.
// R4: Each active-low lane select gates one 9-bit slice of write data.
// R5: A deasserted lane select leaves that lane of memory unchanged.
// R6: Lane selects are sampled with the very word they qualify.
// R7: The shared address is sampled on the true input clock rise.
// R8: Address is 19 bits for 36-bit data; only the low 4 bits are stored, so addresses 16 apart share one burst.
// R9: Without the load strobe the address is ignored and nothing starts.
// R10: Read words leave on true then complementary output clock rises.
// R11: In single clock mode read words leave on the input clock pair.
// R12: With no read data to drive, the read bus is released.
// R13: Controller sets direction high for read, low for write, with the load.
// R14: Every access and all control capture start on a true input clock rise.
// R15: Burst word 0 goes with the true rise, word 1 with the next complement.

// ============================================================================
// Read data FIFO
module dsr_fifo #(
  parameter int WIDTH = dsr_pkg::DATA_W,
  parameter int DEPTH = dsr_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_in,        // System clock
  input  wire logic             rst_n_in,      // Synchronised reset, low active
  input  wire logic             in_valid_in,   // Write side word offered
  output logic                  in_ready_out,  // Write side has room
  input  wire logic [WIDTH-1:0] in_data_in,    // Write side word
  output logic                  out_valid_out, // Read side word present
  input  wire logic             out_ready_in,  // Read side takes a word
  output logic      [WIDTH-1:0] out_data_out   // Read side word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next[DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    wr_next;
  logic [PW-1:0]    rd_reg;
  logic [PW-1:0]    rd_next;
  logic [PW:0]      cnt_reg;
  logic [PW:0]      cnt_next;
  logic             push;
  logic             pop;

  // Honest flags straight from the fill count
  assign in_ready_out  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out  = mem_reg[rd_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  // Pointer wrap is explicit so any depth works, not only powers of two
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_in;
      wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + PW'(1);
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + PW'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - (PW+1)'(1);
    end
  end

  // Register the buffer state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_reg <= '{default: '0};
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : dsr_fifo

// ============================================================================
// SRAM bus port, device side
module dsr_port #(
  parameter int DATA_W = dsr_pkg::DATA_W,
  parameter int ADDR_W = dsr_pkg::ADDR_W,
  parameter int MEM_AW = dsr_pkg::MEM_AW
) (
  input  wire logic                       sys_clk_in,                     // 125 MHz clock
  input  wire logic                       resetn_in,                      // Async reset, low
  input  wire logic                       k_in,                           // True input clock
  input  wire logic                       k_n_in,                         // Complementary input clk
  input  wire logic                       c_in,                           // True output clock
  input  wire logic                       c_n_in,                         // Complementary output clk
  input  wire logic                       single_clock_mode_in,           // Read data on K pair
  input  wire logic                       cycle_load_n_in,                // Load strobe, low
  input  wire logic                       read_write_in,                  // High read, low write
  input  wire logic [ADDR_W-1:0]          addr_in,                        // Shared address
  input  wire logic [DATA_W-1:0]          data_in,                        // Write data
  input  wire logic [DATA_W/9-1:0]        byte_lane_write_select_n_in,    // Lane selects, low
  output logic      [DATA_W-1:0]          q_out,                          // Read data
  output logic                            q_oe_out                        // High while driving q
);
  localparam int NL = DATA_W / dsr_pkg::LANE_W;
  localparam int SW = dsr_pkg::CTRL_BITS + ADDR_W + DATA_W + NL;
  localparam int DEPTH = 1 << MEM_AW;

  logic [1:0]              rst_sync_reg;
  logic                    rst_n;
  logic [SW-1:0]           meta_reg;
  logic [SW-1:0]           sync_reg;
  logic [3:0]              clk_dly_reg;
  logic [SW-1:0]           pins;
  logic [ADDR_W-1:0]       a_s;
  logic [DATA_W-1:0]       d_s;
  logic [NL-1:0]           bws_s;
  logic                    k_rise;
  logic                    kn_rise;
  logic                    c_rise;
  logic                    cn_rise;
  logic                    launch;
  logic [MEM_AW-1:0]       a_idx;
  dsr_pkg::dsr_state_type  state_reg;
  dsr_pkg::dsr_state_type  state_next;
  logic [MEM_AW-1:0]       addr_reg;
  logic [MEM_AW-1:0]       addr_next;
  logic [DATA_W-1:0]       mem0_reg [DEPTH];
  logic [DATA_W-1:0]       mem0_next[DEPTH];
  logic [DATA_W-1:0]       mem1_reg [DEPTH];
  logic [DATA_W-1:0]       mem1_next[DEPTH];
  logic [DATA_W-1:0]       merged0;
  logic [DATA_W-1:0]       merged1;
  logic                    push_valid;
  logic [DATA_W-1:0]       push_data;
  logic                    push_ready;
  logic                    out_valid;
  logic [DATA_W-1:0]       out_data;
  logic                    pop;
  logic [DATA_W-1:0]       q_reg;
  logic [DATA_W-1:0]       q_next;
  logic                    oe_reg;
  logic                    oe_next;

  // ==========================================================================
  // Reset release through two flops
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_reg <= dsr_pkg::RST_SYNC;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================================
  // Pin synchroniser; only sync_reg and later are read by logic
  assign pins = {byte_lane_write_select_n_in, data_in, addr_in, read_write_in,
                 cycle_load_n_in, single_clock_mode_in, c_n_in, c_in, k_n_in, k_in};

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg    <= '0;
      sync_reg    <= '0;
      clk_dly_reg <= '0;
    end else begin
      meta_reg    <= pins;
      sync_reg    <= meta_reg;
      clk_dly_reg <= sync_reg[3:0];
    end
  end

  // Edge finding; clocks and data share the same sync delay, so data
  // read at a detected edge is the data that stood at that link edge
  assign k_rise  = sync_reg[dsr_pkg::POS_K]  && !clk_dly_reg[dsr_pkg::POS_K];   // see R14
  assign kn_rise = sync_reg[dsr_pkg::POS_KN] && !clk_dly_reg[dsr_pkg::POS_KN];
  assign c_rise  = sync_reg[dsr_pkg::POS_C]  && !clk_dly_reg[dsr_pkg::POS_C];
  assign cn_rise = sync_reg[dsr_pkg::POS_CN] && !clk_dly_reg[dsr_pkg::POS_CN];
  assign a_s     = sync_reg[dsr_pkg::CTRL_BITS +: ADDR_W];
  assign d_s     = sync_reg[dsr_pkg::CTRL_BITS + ADDR_W +: DATA_W];
  assign bws_s   = sync_reg[dsr_pkg::CTRL_BITS + ADDR_W + DATA_W +: NL];
  assign a_idx   = a_s[MEM_AW-1:0];  // Upper address bits are not stored  see R8

  // ==========================================================================
  // Lane merge: each select owns one 9-bit slice of its own word
  for (genvar g = 0; g < NL; g++) begin : g_lane
    localparam int LO = g * dsr_pkg::LANE_W;
    assign merged0[LO +: dsr_pkg::LANE_W] = bws_s[g] ?                         // see R5
        mem0_reg[a_idx][LO +: dsr_pkg::LANE_W] : d_s[LO +: dsr_pkg::LANE_W];   // see R4
    assign merged1[LO +: dsr_pkg::LANE_W] = bws_s[g] ?                         // see R6
        mem1_reg[addr_reg][LO +: dsr_pkg::LANE_W] : d_s[LO +: dsr_pkg::LANE_W];
  end

  // ==========================================================================
  // Transaction sequencer; loads seen while a read is still being
  // buffered are dropped, a trade for not queueing commands
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    mem0_next  = mem0_reg;
    mem1_next  = mem1_reg;
    push_valid = 1'b0;
    push_data  = mem0_reg[addr_reg];
    case (state_reg)
      dsr_pkg::ST_IDLE: begin
        if (k_rise && !sync_reg[dsr_pkg::POS_LOAD_N]) begin    // see R9
          addr_next = a_idx;                                   // see R7
          if (sync_reg[dsr_pkg::POS_RW]) begin                 // see R13
            state_next = dsr_pkg::ST_RD_W0;
          end else begin
            mem0_next[a_idx] = merged0;                        // see R1
            state_next       = dsr_pkg::ST_WR_HI;              // see R15
          end
        end
      end
      dsr_pkg::ST_WR_HI: begin
        if (kn_rise) begin
          mem1_next[addr_reg] = merged1;                       // see R1
          state_next          = dsr_pkg::ST_IDLE;              // see R3
        end
      end
      dsr_pkg::ST_RD_W0: begin
        push_valid = 1'b1;
        push_data  = mem0_reg[addr_reg];
        if (push_ready) begin
          state_next = dsr_pkg::ST_RD_W1;
        end
      end
      dsr_pkg::ST_RD_W1: begin
        push_valid = 1'b1;
        push_data  = mem1_reg[addr_reg];
        if (push_ready) begin
          state_next = dsr_pkg::ST_IDLE;                       // see R3
        end
      end
      default: begin
        state_next = dsr_pkg::ST_IDLE;
      end
    endcase
  end

  // Register the sequencer and the array
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dsr_pkg::ST_IDLE;
      addr_reg  <= '0;
      mem0_reg  <= '{default: '0};
      mem1_reg  <= '{default: '0};
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      mem0_reg  <= mem0_next;
      mem1_reg  <= mem1_next;
    end
  end

  // ==========================================================================
  // Read data buffer between array and output launch
  dsr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (dsr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (out_valid),
    .out_ready_in  (pop),
    .out_data_out  (out_data)
  );

  // ==========================================================================
  // Output launch: one word per output clock rise (input clock rise in single clock mode), bus released when empty
  assign launch = sync_reg[dsr_pkg::POS_SINGLE] ? (k_rise || kn_rise)  // see R11
                                                : (c_rise || cn_rise); // see R10
  assign pop    = launch && out_valid;

  always_comb begin
    q_next  = q_reg;
    oe_next = oe_reg;
    if (launch) begin
      oe_next = out_valid;                                     // see R12
      if (out_valid) begin
        q_next = out_data;
      end
    end
  end

  // Register the read bus
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q_reg  <= '0;
      oe_reg <= dsr_pkg::RST_OE;
    end else begin
      q_reg  <= q_next;
      oe_reg <= oe_next;
    end
  end

  assign q_out    = q_reg;
  assign q_oe_out = oe_reg;
endmodule : dsr_port
